/* rtl/ccs_card_to_host_ctrl.sv */
`timescale 1ns/1ps
// Notes on behaviour
// - Writing run bit starts the engine
// - Clearing run finishes current descriptor first
// - Count writeback on completed-flag descriptors
// - Bit 27 suppresses metadata writeback, streaming only
// - Non-incrementing mode affects read addresses only
// - Fetch fault field all ones: log, stop
// - Bus fault field all ones: log, stop
// - Single enables gate same-position flags
// - Interrupt needs enable, logged flag, mask
// - Set alias sets bits written one
// - Clear alias clears bits written one
// - Fetch fault flag bit meanings
// - Bus fault: slave bit1, decode bit0
// - Flags clear on run set; write-one-clear
// - Halt idle flag when idle after run cleared
// - Bad size flag on odd length
// - Bad signature flag; engine stops
// - Misaligned flag on address mismatch
// - Finished flag after completed-flag descriptor
// - Halted flag after stop-flag descriptor
// - Busy reads one while engine busy
// - Offset 0x44 reads flags, clears them
// - Done counter clears on run rise, counts
module ccs_card_to_host_ctrl #(
    parameter bit STREAMING = 1'b1
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Datapath handshake
    input wire logic descAvail,
    input wire logic descFetched,
    input wire logic descMoved,
    input wire ccs_pkg::ccs_event_t events,
    output ccs_pkg::ccs_cmd_t cmd,
    output logic engineBusy,
    // To interrupt mask logic
    output logic [31:0] loggedFlags
);
    // ********************************************
    // Reset synchroniser
    // ********************************************
    logic rstMeta_q;
    logic rstSync_q;
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rstMeta_q <= 1'b0;
            rstSync_q <= 1'b0;
        end
        else
        begin
            rstMeta_q <= 1'b1;
            rstSync_q <= rstMeta_q;
        end
    end
    wire logic rstN = rstSync_q;

    // ********************************************
    // Bus address phase capture
    // ********************************************
    logic wrPend_q;
    logic rdPend_q;
    logic [7:0] addr_q;
    wire logic addrPhase = hsel && htrans[1] && hready;
    always_ff @(posedge clk or negedge rstN)
    begin
        if (!rstN)
        begin
            wrPend_q <= 1'b0;
            rdPend_q <= 1'b0;
            addr_q <= 8'h00;
        end
        else
        begin
            wrPend_q <= addrPhase && hwrite;
            rdPend_q <= addrPhase && !hwrite;
            if (addrPhase)
                addr_q <= {haddr[7:2], 2'b00};
        end
    end

    // Zero-wait slave, always OKAY
    always_ff @(posedge clk or negedge rstN)
    begin
        if (!rstN)
        begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
        else
        begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    // ********************************************
    // Control register and aliases
    // ********************************************
    logic [31:0] ctrl_q;
    logic [31:0] ctrl_d;
    always_comb
    begin
        ctrl_d = ctrl_q;
        if (wrPend_q)
        begin
            case (addr_q)
                ccs_pkg::OFF_CTRL: ctrl_d = hwdata & ccs_pkg::CTRL_MASK;
                ccs_pkg::OFF_CTRL_SET: ctrl_d = ctrl_q | (hwdata & ccs_pkg::CTRL_MASK);
                ccs_pkg::OFF_CTRL_CLR: ctrl_d = ctrl_q & ~hwdata;
                default: ctrl_d = ctrl_q;
            endcase
        end
    end
    always_ff @(posedge clk or negedge rstN)
    begin
        if (!rstN)
            ctrl_q <= ccs_pkg::CTRL_RESET;
        else
            ctrl_q <= ctrl_d;
    end
    wire logic runBit = ctrl_q[ccs_pkg::BIT_RUN];
    wire logic runRise = ctrl_d[ccs_pkg::BIT_RUN] && !runBit;
    wire logic fetchAllOn = ctrl_q[ccs_pkg::FLD_FETCH_LO +: 5] == ccs_pkg::FIELD_ALL_ONES;
    wire logic busAllOn = ctrl_q[ccs_pkg::FLD_BUS_LO +: 5] == ccs_pkg::FIELD_ALL_ONES;

    // ********************************************
    // Flag sources
    // ********************************************
    ccs_pkg::ccs_state_t state_q;
    logic [31:0] flags_q;
    logic [31:0] hwSet;
    logic errStop;
    logic idleEvent;
    always_comb
    begin
        hwSet = 32'h0000_0000;
        if (fetchAllOn)
            hwSet[ccs_pkg::FLD_FETCH_LO +: 5] = events.fetchFault;
        if (busAllOn)
            hwSet[ccs_pkg::FLD_BUS_LO +: 2] = events.busFault;
        hwSet[ccs_pkg::BIT_HALT_IDLE] = idleEvent && ctrl_q[ccs_pkg::BIT_HALT_IDLE];
        hwSet[ccs_pkg::BIT_BAD_SIZE] = events.badSize && ctrl_q[ccs_pkg::BIT_BAD_SIZE];
        hwSet[ccs_pkg::BIT_BAD_SIGNATURE] = events.badSignature
            && ctrl_q[ccs_pkg::BIT_BAD_SIGNATURE];
        hwSet[ccs_pkg::BIT_MISALIGNED] = events.misaligned && ctrl_q[ccs_pkg::BIT_MISALIGNED];
        hwSet[ccs_pkg::BIT_DESC_FINISHED] = events.descDone && events.descComplete
            && ctrl_q[ccs_pkg::BIT_DESC_FINISHED];
        // Gated by its own enable, not the signature enable
        hwSet[ccs_pkg::BIT_DESC_HALTED] = events.descDone && events.descStop
            && ctrl_q[ccs_pkg::BIT_DESC_HALTED];
    end
    // Bad signature stops whether or not it is logged
    assign errStop = (fetchAllOn && |events.fetchFault) || (busAllOn && |events.busFault)
        || events.badSignature;

    // ********************************************
    // Status flags
    // ********************************************
    wire logic w1cHit = wrPend_q && addr_q == ccs_pkg::OFF_STAT;
    wire logic rcHit = rdPend_q && addr_q == ccs_pkg::OFF_STAT_RC;
    logic [31:0] swClr;
    always_comb
    begin
        swClr = 32'h0000_0000;
        if (w1cHit)
            swClr = hwdata;
        if (rcHit)
            // Only what the read returned, so a flag set meanwhile is kept
            swClr = hrdata;
    end
    always_ff @(posedge clk or negedge rstN)
    begin
        if (!rstN)
            flags_q <= 32'h0000_0000;
        else if (runRise)
            flags_q <= 32'h0000_0000;
        else
            flags_q <= ((flags_q & ~swClr) | hwSet) & ccs_pkg::FLAG_MASK;
    end

    // ********************************************
    // Engine sequencer
    // ********************************************
    always_ff @(posedge clk or negedge rstN)
    begin
        if (!rstN)
        begin
            state_q <= ccs_pkg::ST_IDLE;
            idleEvent <= 1'b0;
        end
        else
        begin
            idleEvent <= 1'b0;
            case (state_q)
                ccs_pkg::ST_IDLE:
                    if (runBit && descAvail)
                        state_q <= ccs_pkg::ST_FETCH;
                ccs_pkg::ST_FETCH:
                    if (errStop)
                    begin
                        state_q <= ccs_pkg::ST_IDLE;
                        idleEvent <= !runBit;
                    end
                    else if (descFetched)
                        state_q <= ccs_pkg::ST_MOVE;
                // Run low does not cut a descriptor short
                ccs_pkg::ST_MOVE:
                    if (errStop)
                    begin
                        state_q <= ccs_pkg::ST_IDLE;
                        idleEvent <= !runBit;
                    end
                    else if (descMoved)
                    begin
                        if (!runBit || events.descStop)
                        begin
                            state_q <= ccs_pkg::ST_IDLE;
                            idleEvent <= !runBit;
                        end
                        else
                            state_q <= ccs_pkg::ST_FETCH;
                    end
                default:
                    state_q <= ccs_pkg::ST_IDLE;
            endcase
        end
    end

    // ********************************************
    // Completed descriptor counter
    // ********************************************
    logic [31:0] doneCnt_q;
    always_ff @(posedge clk or negedge rstN)
    begin
        if (!rstN)
            doneCnt_q <= 32'h0000_0000;
        else if (runRise)
            doneCnt_q <= 32'h0000_0000;
        else if (events.descDone)
            doneCnt_q <= doneCnt_q + 32'h0000_0001;
    end

    // ********************************************
    // Outputs to datapath
    // ********************************************
    always_ff @(posedge clk or negedge rstN)
    begin
        if (!rstN)
        begin
            cmd <= '0;
            engineBusy <= 1'b0;
            loggedFlags <= 32'h0000_0000;
        end
        else
        begin
            cmd.fetchReq <= state_q == ccs_pkg::ST_FETCH;
            cmd.moveReq <= state_q == ccs_pkg::ST_MOVE;
            cmd.countWb <= ctrl_q[ccs_pkg::BIT_COUNT_WB] && events.descDone && events.descComplete;
            cmd.metaWb <= !(STREAMING && ctrl_q[ccs_pkg::BIT_NO_META_WB]);
            cmd.nonIncRead <= ctrl_q[ccs_pkg::BIT_NON_INC];
            engineBusy <= state_q != ccs_pkg::ST_IDLE;
            // Mask logic downstream completes the interrupt gate
            loggedFlags <= flags_q;
        end
    end

    // ********************************************
    // Read data
    // ********************************************
    always_ff @(posedge clk or negedge rstN)
    begin
        if (!rstN)
            hrdata <= 32'h0000_0000;
        else if (addrPhase && !hwrite)
        begin
            case ({haddr[7:2], 2'b00})
                ccs_pkg::OFF_CTRL: hrdata <= ctrl_d;
                ccs_pkg::OFF_STAT,
                ccs_pkg::OFF_STAT_RC: hrdata <= flags_q | {31'h0, state_q != ccs_pkg::ST_IDLE};
                ccs_pkg::OFF_DONE_CNT: hrdata <= doneCnt_q;
                default: hrdata <= 32'h0000_0000;
            endcase
        end
    end

    // ********************************************
    // Checks
    // ********************************************
    property p_set_alias;
        @(posedge clk) disable iff (!rstN)
        wrPend_q && addr_q == ccs_pkg::OFF_CTRL_SET |=> (ctrl_q & $past(hwdata) & ccs_pkg::CTRL_MASK)
            == ($past(hwdata) & ccs_pkg::CTRL_MASK);
    endproperty
    a_set_alias: assert property (p_set_alias) else $error("set alias lost a bit");
    property p_clr_alias;
        @(posedge clk) disable iff (!rstN)
        wrPend_q && addr_q == ccs_pkg::OFF_CTRL_CLR |=> (ctrl_q & $past(hwdata)) == 32'h0;
    endproperty
    a_clr_alias: assert property (p_clr_alias) else $error("clear alias kept a bit");
    property p_run_clears;
        @(posedge clk) disable iff (!rstN)
        runRise |=> flags_q == 32'h0 && doneCnt_q == 32'h0;
    endproperty
    a_run_clears: assert property (p_run_clears) else $error("run rise did not clear");
    property p_set_wins;
        @(posedge clk) disable iff (!rstN)
        !runRise && hwSet[ccs_pkg::BIT_DESC_FINISHED] |=> flags_q[ccs_pkg::BIT_DESC_FINISHED];
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("event lost to clear");
    sequence s_moving_run_off;
        state_q == ccs_pkg::ST_MOVE && !runBit && !descMoved && !errStop;
    endsequence
    property p_finish_desc;
        @(posedge clk) disable iff (!rstN)
        s_moving_run_off |=> state_q == ccs_pkg::ST_MOVE;
    endproperty
    a_finish_desc: assert property (p_finish_desc) else $error("descriptor aborted");
    property p_busy;
        @(posedge clk) disable iff (!rstN)
        1'b1 |=> engineBusy == ($past(state_q) != ccs_pkg::ST_IDLE);
    endproperty
    a_busy: assert property (p_busy) else $error("busy mismatch");
    property p_rc_clear;
        @(posedge clk) disable iff (!rstN)
        rcHit && !runRise |=> (flags_q & $past(hrdata) & ~$past(hwSet) & ccs_pkg::FLAG_MASK) == 32'h0;
    endproperty
    a_rc_clear: assert property (p_rc_clear) else $error("read clear failed");
    property p_fetch_gate;
        @(posedge clk) disable iff (!rstN)
        !fetchAllOn && !w1cHit |=> $stable(flags_q[23:19]) || $past(runRise) || $past(rcHit);
    endproperty
    a_fetch_gate: assert property (p_fetch_gate) else $error("fetch fault logged ungated");
    property p_halted_flag;
        @(posedge clk) disable iff (!rstN)
        events.descDone && events.descStop && ctrl_q[ccs_pkg::BIT_DESC_HALTED] && !runRise
            |=> flags_q[ccs_pkg::BIT_DESC_HALTED];
    endproperty
    a_halted_flag: assert property (p_halted_flag) else $error("halted flag missing");
    property p_count;
        @(posedge clk) disable iff (!rstN)
        events.descDone && !runRise |=> doneCnt_q == $past(doneCnt_q) + 32'h1;
    endproperty
    a_count: assert property (p_count) else $error("counter did not step");
    property p_rc_keeps;
        @(posedge clk) disable iff (!rstN)
        rcHit && !runRise |=> ($past(flags_q) & ~$past(hrdata) & ccs_pkg::FLAG_MASK & ~flags_q) == 32'h0;
    endproperty
    a_rc_keeps: assert property (p_rc_keeps) else $error("unread flag lost");
    property p_idle_flag;
        @(posedge clk) disable iff (!rstN)
        idleEvent && ctrl_q[ccs_pkg::BIT_HALT_IDLE] && !runRise |=> flags_q[ccs_pkg::BIT_HALT_IDLE];
    endproperty
    a_idle_flag: assert property (p_idle_flag) else $error("idle flag missing");
    property p_err_stop;
        @(posedge clk) disable iff (!rstN)
        state_q != ccs_pkg::ST_IDLE && errStop |=> state_q == ccs_pkg::ST_IDLE;
    endproperty
    a_err_stop: assert property (p_err_stop) else $error("engine ran on after fault");
endmodule : ccs_card_to_host_ctrl

/* shared/ccs_pkg.sv */
package ccs_pkg;
    // ********************************************
    // Register byte offsets
    // ********************************************
    localparam logic [7:0] OFF_CTRL = 8'h04;
    localparam logic [7:0] OFF_CTRL_SET = 8'h08;
    localparam logic [7:0] OFF_CTRL_CLR = 8'h0c;
    localparam logic [7:0] OFF_STAT = 8'h40;
    localparam logic [7:0] OFF_STAT_RC = 8'h44;
    localparam logic [7:0] OFF_DONE_CNT = 8'h48;
    // ********************************************
    // Field positions and masks
    // ********************************************
    localparam int BIT_RUN = 0;
    localparam int BIT_DESC_HALTED = 1;
    localparam int BIT_DESC_FINISHED = 2;
    localparam int BIT_MISALIGNED = 3;
    localparam int BIT_BAD_SIGNATURE = 4;
    localparam int BIT_BAD_SIZE = 5;
    localparam int BIT_HALT_IDLE = 6;
    localparam int BIT_NON_INC = 25;
    localparam int BIT_COUNT_WB = 26;
    localparam int BIT_NO_META_WB = 27;
    localparam int FLD_BUS_LO = 9;
    localparam int FLD_FETCH_LO = 19;
    localparam logic [31:0] CTRL_MASK = 32'h0ef8_3e7f;
    localparam logic [31:0] FLAG_MASK = 32'h00f8_3e7e;
    localparam logic [31:0] BUS_FLAG_MASK = 32'h0000_0600;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [4:0] FIELD_ALL_ONES = 5'h1f;
    // ********************************************
    // Engine states and carriers
    // ********************************************
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_FETCH = 2'b01,
        ST_MOVE = 2'b10
    } ccs_state_t;
    typedef struct packed {
        logic descDone;
        logic descComplete;
        logic descStop;
        logic badSignature;
        logic badSize;
        logic misaligned;
        logic [4:0] fetchFault;
        logic [1:0] busFault;
    } ccs_event_t;
    typedef struct packed {
        logic fetchReq;
        logic moveReq;
        logic countWb;
        logic metaWb;
        logic nonIncRead;
    } ccs_cmd_t;
endpackage : ccs_pkg

/* verif/card_to_host_channel_ctrl_status_tb.sv */
`timescale 1ns/1ps
module card_to_host_channel_ctrl_status_tb;
    // ****************************************
    // Stimulus and observed signals
    // ****************************************
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic hsel = 1'b0;
    logic [7:0] haddr = 8'h00;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h0;
    logic [31:0] hwdata = 32'h0;
    logic descAvail = 1'b0;
    logic descFetched = 1'b0;
    logic descMoved = 1'b0;
    ccs_pkg::ccs_event_t events = '0;
    logic [31:0] hrdata;
    logic [31:0] loggedFlags;
    logic hreadyout;
    logic hresp;
    logic engineBusy;
    ccs_pkg::ccs_cmd_t cmd;
    int errTotal = 0;
    int checks = 0;
    int wbCount = 0;
    always #20 clk = ~clk;
    // Single slave, so its ready is the bus ready
    ccs_card_to_host_ctrl #(.STREAMING(1'b1)) ccs_card_to_host_ctrl_inst (
        .clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .descAvail(descAvail), .descFetched(descFetched), .descMoved(descMoved),
        .events(events), .cmd(cmd), .engineBusy(engineBusy), .loggedFlags(loggedFlags)
    );
    always @(posedge clk)
    begin
        if (cmd.countWb === 1'b1) wbCount <= wbCount + 1;
    end
    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks, errTotal);
        if (errTotal == 0 && checks > 0)
        begin
            $display("ALL TESTS PASSED");
        end
        else
        begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : report_and_stop
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            errTotal++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] r);
        int n;
        n = 0;
        @(posedge clk);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'b10;
        hwrite <= w;
        hsize <= 3'b010;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (hreadyout !== 1'b1 && n < 50);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (hreadyout !== 1'b1 && n < 100);
        r = hrdata;
        if (n >= 50)
        begin
            errTotal++;
            report_and_stop();
        end
    endtask : xfer
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        xfer(a, 1'b1, d, r);
    endtask : wr
    task automatic rdChk(input string what, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] r;
        xfer(a, 1'b0, 32'h0, r);
        chk(what, r, exp);
    endtask : rdChk
    task automatic waitBusy(input logic exp);
        int n;
        for (n = 0; n < 40 && engineBusy !== exp; n++) @(posedge clk);
        chk("engineBusy", {31'h0, engineBusy}, {31'h0, exp});
        if (engineBusy !== exp)
            report_and_stop();
    endtask : waitBusy
    task automatic fetched();
        @(posedge clk);
        descFetched <= 1'b1;
        @(posedge clk);
        descFetched <= 1'b0;
        repeat (2) @(posedge clk);
    endtask : fetched
    // Events are one-cycle pulses, optionally with the move completion
    task automatic fire(input ccs_pkg::ccs_event_t ev, input logic moved);
        @(posedge clk);
        events <= ev;
        descMoved <= moved;
        @(posedge clk);
        events <= '0;
        descMoved <= 1'b0;
        repeat (3) @(posedge clk);
    endtask : fire
    // Run edge also clears the flags, so every test restarts from a clean status
    task automatic startOne(input logic [31:0] ctrl);
        wr(ccs_pkg::OFF_CTRL, 32'h0);
        wr(ccs_pkg::OFF_CTRL, ctrl);
        descAvail <= 1'b1;
        waitBusy(1'b1);
        descAvail <= 1'b0;
    endtask : startOne
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic testRegs();
        rdChk("ctrl reset", ccs_pkg::OFF_CTRL, ccs_pkg::CTRL_RESET);
        rdChk("status reset", ccs_pkg::OFF_STAT, 32'h0);
        wr(8'h10, 32'hffff_ffff);
        rdChk("unmapped", 8'h10, 32'h0);
        wr(ccs_pkg::OFF_CTRL, 32'hffff_fffe);
        rdChk("ctrl rw", ccs_pkg::OFF_CTRL, 32'h0ef8_3e7e);
        wr(ccs_pkg::OFF_CTRL_CLR, 32'h0ef0_0000);
        rdChk("ctrl clr", ccs_pkg::OFF_CTRL, 32'h0008_3e7e);
        wr(ccs_pkg::OFF_CTRL_SET, 32'h0200_0000);
        rdChk("ctrl set", ccs_pkg::OFF_CTRL, 32'h0208_3e7e);
        chk("hresp", {31'h0, hresp}, 32'h0);
        wr(ccs_pkg::OFF_CTRL, 32'h0);
        $display("test regs done");
    endtask : testRegs
    task automatic testFlow();
        ccs_pkg::ccs_event_t ev;
        int wb0;
        ev = '0;
        wb0 = wbCount;
        startOne(32'h0e00_0047);
        chk("fetchReq", {31'h0, cmd.fetchReq}, 32'h1);
        chk("nonIncRead", {31'h0, cmd.nonIncRead}, 32'h1);
        chk("metaWb", {31'h0, cmd.metaWb}, 32'h0);
        rdChk("busy", ccs_pkg::OFF_STAT, 32'h1);
        fetched();
        chk("moveReq", {31'h0, cmd.moveReq}, 32'h1);
        wr(ccs_pkg::OFF_CTRL_CLR, 32'h1);
        repeat (3) @(posedge clk);
        chk("busy after stop", {31'h0, engineBusy}, 32'h1);
        ev.descDone = 1'b1;
        ev.descComplete = 1'b1;
        ev.descStop = 1'b1;
        fire(ev, 1'b1);
        waitBusy(1'b0);
        rdChk("flags", ccs_pkg::OFF_STAT, 32'h0000_0046);
        chk("logged", loggedFlags, 32'h0000_0046);
        chk("count wb", wbCount - wb0, 32'h1);
        rdChk("done count", ccs_pkg::OFF_DONE_CNT, 32'h1);
        $display("test flow done");
    endtask : testFlow
    task automatic testFaults();
        ccs_pkg::ccs_event_t ev;
        ev = '0;
        startOne(32'h00f8_3e01);
        rdChk("run clears", ccs_pkg::OFF_STAT, 32'h1);
        rdChk("count clears", ccs_pkg::OFF_DONE_CNT, 32'h0);
        chk("metaWb on", {31'h0, cmd.metaWb}, 32'h1);
        chk("nonIncRead off", {31'h0, cmd.nonIncRead}, 32'h0);
        ev.fetchFault = 5'h15;
        fire(ev, 1'b0);
        waitBusy(1'b0);
        rdChk("fetch field", ccs_pkg::OFF_STAT, 32'h00a8_0000);
        wr(ccs_pkg::OFF_STAT, 32'h0080_0000);
        rdChk("w1c", ccs_pkg::OFF_STAT, 32'h0028_0000);
        rdChk("read clear", ccs_pkg::OFF_STAT_RC, 32'h0028_0000);
        rdChk("after rc", ccs_pkg::OFF_STAT, 32'h0);
        startOne(32'h00f8_3e01);
        fetched();
        ev = '0;
        ev.busFault = 2'b10;
        fire(ev, 1'b0);
        waitBusy(1'b0);
        rdChk("bus field", ccs_pkg::OFF_STAT, 32'h0000_0400);
        // Partial field: no logging and no stop
        startOne(32'h00f8_3c01);
        ev.busFault = 2'b01;
        fire(ev, 1'b0);
        rdChk("bus unlogged", ccs_pkg::OFF_STAT, 32'h1);
        wr(ccs_pkg::OFF_CTRL_CLR, 32'h1);
        fetched();
        ev = '0;
        ev.descDone = 1'b1;
        fire(ev, 1'b1);
        waitBusy(1'b0);
        $display("test faults done");
    endtask : testFaults
    task automatic testSignature();
        ccs_pkg::ccs_event_t ev;
        ev = '0;
        startOne(32'h0000_0029);
        ev.badSize = 1'b1;
        ev.misaligned = 1'b1;
        fire(ev, 1'b0);
        chk("still busy", {31'h0, engineBusy}, 32'h1);
        ev = '0;
        ev.badSignature = 1'b1;
        fire(ev, 1'b0);
        waitBusy(1'b0);
        rdChk("gated flags", ccs_pkg::OFF_STAT, 32'h0000_0028);
        $display("test signature done");
    endtask : testSignature
    // Reset in mid-run, with the engine busy
    task automatic testReset();
        startOne(32'h0000_0041);
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        chk("busy in reset", {31'h0, engineBusy}, 32'h0);
        chk("ready in reset", {31'h0, hreadyout}, 32'h1);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        chk("busy after reset", {31'h0, engineBusy}, 32'h0);
        chk("logged after reset", loggedFlags, 32'h0);
        rdChk("ctrl after reset", ccs_pkg::OFF_CTRL, ccs_pkg::CTRL_RESET);
        rdChk("status after reset", ccs_pkg::OFF_STAT, 32'h0);
        $display("test reset done");
    endtask : testReset
    // ****************************************
    // Main sequence
    // ****************************************
    initial
    begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        testRegs();
        testFlow();
        testFaults();
        testSignature();
        testReset();
        report_and_stop();
    end
    initial
    begin
        repeat (20000) @(posedge clk);
        errTotal++;
        report_and_stop();
    end
endmodule : card_to_host_channel_ctrl_status_tb
